// >>> common/tws_map.vh
// Constants of the two-wire serial memory slave.
// Assumes inclusion by the design files only; definitions only.
`ifndef TWS_MAP_VH
`define TWS_MAP_VH
`define TWS_TYPE_CODE 4'ha
`define TWS_PAGE_BITS 6
`define TWS_ADDR_BITS_SMALL 14
`define TWS_ADDR_BITS_LARGE 15
`define TWS_WR_TIME_MS 5
`define TWS_CLK_MHZ 250
`define TWS_WR_CYCLES (`TWS_WR_TIME_MS * 1000 * `TWS_CLK_MHZ)
`define TWS_FIFO_DEPTH 8
`endif

// >>> verilog/tws_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/100ps
module tws_fifo #(
	parameter WIDTH = 23,
	parameter DEPTH = 8,
	parameter AW = 3
)(
	input wire clk,
	input wire resetn,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0] wr_ptr;
	reg [AW:0] rd_ptr;
	wire full;
	wire empty;
	assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign empty = (wr_ptr == rd_ptr);
	assign in_ready = ~full;
	assign out_valid = ~empty;
	assign out_data = mem[rd_ptr[AW-1:0]];
	always @(posedge clk)
	begin
		if (in_valid && !full)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_ptr <= {(AW+1){1'b0}};
			rd_ptr <= {(AW+1){1'b0}};
		end
		else
		begin
			if (in_valid && !full)
				wr_ptr <= wr_ptr + 1'b1;
			if (out_ready && !empty)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule // tws_fifo

// >>> verilog/tws_slave.v
// Two-wire serial memory slave: protocol engine, array and write buffer.
// Assumes scl, sda and straps come from pins and are synchronised here.
// Overview of operation
// R1 - Small variant: 256 pages of 64 bytes, 14-bit word address.
// R2 - Large variant: 512 pages of 64 bytes, 15-bit word address.
// R3 - SDA changes only with SCL low; changes with SCL high are start or stop.
// R4 - Every command opens with a start: SDA falls while SCL high.
// R5 - Stop is SDA rising while SCL high; returns device to standby.
// R6 - Words are 8 bits, MSB first; each received word is acked in ninth clock.
// R7 - Standby at power-up and after stop once internal write finishes.
// R8 - Master recovers a hung bus with up to 9 clocks then a start.
// R9 - Device address word follows start; upper four bits are 1010.
// R10 - Three chip-select bits compare to straps; up to eight devices.
// R11 - Address LSB selects direction: one read, zero write.
// R12 - Match gives ack low; mismatch gives no ack and standby.
// R13 - Write-protect high blocks all array writes; low allows them.
// R14 - Byte write: address, word address, data, stop starts write cycle.
// R15 - During the write cycle inputs are ignored and nothing is acked.
// R16 - Page write accepts up to 64 bytes, each acked.
// R17 - Write increments only low six address bits, wrapping in the page.
// R18 - Polling: address acked only once the internal write has finished.
// R19 - Address counter holds last address plus one; reads wrap at array end.
// R20 - Current-address read shifts out the byte at the counter.
// R21 - Random read loads the address by dummy write then repeated start.
// R22 - Each acked read byte advances the address; nack then stop ends it.
// R23 - Sample SDA on SCL rise, change output SDA after SCL fall.
// R24 - Write cycle time runs from the ending stop until programming ends.
// R25 - Write cycle length is a parameter counted in system clocks.
// R26 - SDA is open drain, released except for ack or read data bits.
`timescale 1ns/100ps
`include "tws_map.vh"
module tws_slave #(
	parameter ADDR_BITS = `TWS_ADDR_BITS_LARGE,
	parameter WR_CYCLES = `TWS_WR_CYCLES
)(
	input wire clk,
	input wire resetn,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe,
	input wire chip_select_strap_0,
	input wire chip_select_strap_1,
	input wire chip_select_strap_2,
	input wire write_protect,
	output reg busy
);
	localparam MEM_SIZE = 1 << ADDR_BITS;
	localparam S_IDLE = 7'h01;
	localparam S_DEV = 7'h02;
	localparam S_ADDH = 7'h04;
	localparam S_ADDL = 7'h08;
	localparam S_WDAT = 7'h10;
	localparam S_RDAT = 7'h20;
	localparam S_RACK = 7'h40;
	localparam FW = 8 + ADDR_BITS;
	reg [7:0] mem [0:MEM_SIZE-1];
	reg [1:0] scl_s;
	reg [1:0] sda_s;
	reg [1:0] wp_s;
	reg scl_d;
	reg sda_d;
	reg [6:0] state;
	reg [3:0] bit_cnt;
	reg [7:0] shift;
	reg rd_dir;
	reg wr_seen;
	reg [ADDR_BITS-1:0] addr;
	reg [7:0] rd_byte;
	reg [31:0] wr_timer;
	reg f_valid;
	reg [FW-1:0] f_data;
	reg ack_phase;
	reg [7:0] page_buf [0:63];
	reg [63:0] page_vld;
	reg [ADDR_BITS-7:0] page_row;
	reg [6:0] commit_idx;
	wire f_ready;
	wire q_valid;
	wire [FW-1:0] q_data;
	wire scl;
	wire sda;
	wire [2:0] cs;
	wire scl_rise;
	wire scl_fall;
	wire start_det;
	wire stop_det;
	wire dev_match;
	wire drain;
	wire [2:0] strap_pins;
	genvar g;
	assign scl = scl_s[1];
	assign sda = sda_s[1];
	assign strap_pins = {chip_select_strap_2, chip_select_strap_1, chip_select_strap_0};
	assign drain = !busy;
	assign scl_rise = scl && !scl_d;
	assign scl_fall = !scl && scl_d;
	assign start_det = scl && scl_d && sda_d && !sda; // R3 R4
	assign stop_det = scl && scl_d && !sda_d && sda; // R3 R5
	assign dev_match = (shift[7:4] == `TWS_TYPE_CODE) && (shift[3:1] == cs); // R9 R10
	// Pin synchronisers
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			wp_s <= 2'h0;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end
		else
		begin
			scl_s <= {scl_s[0], scl_in};
			sda_s <= {sda_s[0], sda_in};
			wp_s <= {wp_s[0], write_protect};
			scl_d <= scl;
			sda_d <= sda;
		end
	end
	// Strap synchronisers, one per chip-select pin
	generate
		for (g = 0; g < 3; g = g + 1)
		begin : g_strap
			reg [1:0] strap_s;
			always @(posedge clk or negedge resetn)
			begin
				if (!resetn)
					strap_s <= 2'h0;
				else
					strap_s <= {strap_s[0], strap_pins[g]};
			end
			assign cs[g] = strap_s[1]; // R10
		end
	endgenerate
	// Write buffer between bus receive and array programming
	tws_fifo #(.WIDTH(FW), .DEPTH(`TWS_FIFO_DEPTH), .AW(3)) u_fifo (
		.clk(clk),
		.resetn(resetn),
		.in_valid(f_valid),
		.in_ready(f_ready),
		.in_data(f_data),
		.out_valid(q_valid),
		.out_ready(drain),
		.out_data(q_data)
	);
	// Page buffer collects a whole page, so all 64 bytes fit past the FIFO
	always @(posedge clk)
	begin
		if (q_valid && drain)
			page_buf[q_data[13:8]] <= q_data[7:0]; // R17
	end
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			page_vld <= 64'h0;
			page_row <= {(ADDR_BITS-6){1'b0}};
			commit_idx <= 7'h00;
		end
		else if (busy)
		begin
			if (!commit_idx[6])
			begin
				page_vld[commit_idx[5:0]] <= 1'b0;
				commit_idx <= commit_idx + 7'h01;
			end
		end
		else
		begin
			commit_idx <= 7'h00;
			if (q_valid)
			begin
				page_vld[q_data[13:8]] <= 1'b1; // R16
				page_row <= q_data[FW-1:14];
			end
		end
	end
	// Array programming commits the page during the write cycle
	always @(posedge clk)
	begin
		if (busy && !commit_idx[6] && page_vld[commit_idx[5:0]])
			mem[{page_row, commit_idx[5:0]}] <= page_buf[commit_idx[5:0]]; // R24
	end
	// Protocol engine
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state <= S_IDLE; // R7
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			rd_dir <= 1'b0;
			wr_seen <= 1'b0;
			ack_phase <= 1'b0;
			addr <= {ADDR_BITS{1'b0}};
			rd_byte <= 8'h00;
			wr_timer <= 32'h0;
			busy <= 1'b0;
			f_valid <= 1'b0;
			f_data <= {FW{1'b0}};
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
		end
		else
		begin
			f_valid <= 1'b0;
			if (busy)
			begin
				sda_oe <= 1'b0; // R15 R18
				if (wr_timer != 32'h0)
					wr_timer <= wr_timer - 32'h1; // R24 R25
				else if (commit_idx[6])
					busy <= 1'b0; // R7
			end
			else if (stop_det)
			begin
				sda_oe <= 1'b0;
				state <= S_IDLE; // R5
				if (wr_seen)
				begin
					busy <= 1'b1; // R14
					wr_timer <= WR_CYCLES[31:0] - 32'h1;
				end
				wr_seen <= 1'b0;
			end
			else if (start_det)
			begin
				sda_oe <= 1'b0;
				state <= S_DEV;
				bit_cnt <= 4'h0;
				ack_phase <= 1'b0;
			end
			else if (state != S_IDLE)
			begin
				if (scl_rise)
				begin
					if (bit_cnt < 4'h8)
						shift <= {shift[6:0], sda}; // R6 R23
					else if (state == S_RACK)
					begin
						if (sda)
							state <= S_IDLE; // R22
						else
						begin
							state <= S_RDAT; // R22
							rd_byte <= mem[addr];
							addr <= addr + 1'b1; // R19
						end
					end
					ack_phase <= (bit_cnt == 4'h8);
					bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
				end
				else if (scl_fall)
				begin
					sda_oe <= 1'b0; // R26
					if (bit_cnt == 4'h8 && state != S_RDAT && state != S_RACK)
					begin
						case (state)
						S_DEV:
						begin
							if (dev_match)
							begin
								sda_out <= 1'b0;
								sda_oe <= 1'b1; // R12
								rd_dir <= shift[0]; // R11
								if (shift[0])
								begin
									rd_byte <= mem[addr]; // R20
									addr <= addr + 1'b1;
								end
							end
							else
								state <= S_IDLE; // R12
						end
						S_ADDH:
						begin
							sda_out <= 1'b0;
							sda_oe <= 1'b1; // R6
							addr[ADDR_BITS-1:8] <= shift[ADDR_BITS-9:0]; // R1 R2
						end
						S_ADDL:
						begin
							sda_out <= 1'b0;
							sda_oe <= 1'b1;
							addr[7:0] <= shift; // R21
						end
						S_WDAT:
						begin
							sda_out <= 1'b0;
							sda_oe <= 1'b1; // R16
							if (!wp_s[1] && f_ready)
							begin
								f_valid <= 1'b1; // R13
								f_data <= {addr, shift};
								wr_seen <= 1'b1;
							end
							addr[5:0] <= addr[5:0] + 6'h01; // R17
						end
						default:
							state <= S_IDLE;
						endcase
					end
					else if (bit_cnt == 4'h0 && ack_phase && state != S_RDAT && state != S_RACK)
					begin
						case (state)
						S_DEV:
							state <= rd_dir ? S_RDAT : S_ADDH;
						S_ADDH:
							state <= S_ADDL;
						S_ADDL:
							state <= S_WDAT;
						default:
							state <= state;
						endcase
						if (state == S_DEV && rd_dir)
						begin
							sda_out <= rd_byte[7];
							sda_oe <= ~rd_byte[7]; // R23 R26
							shift <= rd_byte;
						end
					end
					else if (state == S_RDAT)
					begin
						if (bit_cnt == 4'h8)
							state <= S_RACK; // R26
						else if (bit_cnt == 4'h0)
						begin
							shift <= rd_byte;
							sda_out <= rd_byte[7];
							sda_oe <= ~rd_byte[7]; // R22
						end
						else
						begin
							sda_out <= shift[7];
							sda_oe <= ~shift[7]; // R6 R23
						end
					end
				end
			end
		end
	end
endmodule // tws_slave

// >>> test/tws_chk.sv
// Port checks of the serial memory slave.
// Assumes binding into tws_slave with a pulled-up data line.
`timescale 1ns/100ps
module tws_chk #(
	parameter WR_CYCLES = 200
)(
	input wire clk,
	input wire resetn,
	input wire scl_in,
	input wire sda_in,
	input wire sda_out,
	input wire sda_oe,
	input wire write_protect,
	input wire busy
);
	reg [31:0] bcnt;
	reg [3:0] age;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	always @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			bcnt <= 32'h0;
			age <= 4'hf;
		end
		else
		begin
			bcnt <= busy ? bcnt + 32'h1 : 32'h0;
			age <= (scl_in && sda_in && !$past(sda_in)) ? 4'h0 : age + {3'h0, age != 4'hf};
		end
	a_drive_low: assert property (sda_oe |-> !sda_out) else $error("drive high");
	a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
		else $error("drive moved");
	a_scl_high: assert property (scl_in && $past(scl_in, 4) |-> $stable(sda_oe))
		else $error("drive moved with clock high");
	a_busy_nack: assert property (busy |-> !sda_oe) else $error("ack while busy");
	a_busy_stop: assert property ($rose(busy) |-> age < 4'hc) else $error("no stop");
	a_busy_len: assert property ($fell(busy) |-> bcnt >= WR_CYCLES && bcnt < WR_CYCLES + 1000)
		else $error("write cycle length");
	a_wp_block: assert property ($rose(busy) |-> !write_protect) else $error("protected");
	a_reset_idle: assert property ($rose(resetn) |-> !busy && !sda_oe) else $error("reset");
	cover property ($rose(busy));
	cover property ($rose(sda_oe) && !busy);
	cover property (age == 4'h0);
endmodule // tws_chk
bind tws_slave tws_chk #(.WR_CYCLES(WR_CYCLES)) chk_u (.clk(clk), .resetn(resetn),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.write_protect(write_protect), .busy(busy));

// >>> test/tws_master.sv
// Behavioural two-wire bus master at the far side of the slave.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/100ps
module tws_master (
	input wire clk,
	input wire sda,
	output reg scl,
	output reg sda_low
);
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task wt;
		repeat (10) @(negedge clk);
	endtask
	task cond(input s);
		sda_low = !s;
		wt;
		scl = 1'b1;
		wt;
		sda_low = s;
		wt;
		scl = !s;
		wt;
	endtask
	task bitx(input b, output r);
		sda_low = !b;
		wt;
		scl = 1'b1;
		wt;
		r = sda;
		wt;
		scl = 1'b0;
		wt;
	endtask
	task xfer(input [7:0] d, input b9, output [7:0] q, output r);
		integer i;
		for (i = 7; i >= 0; i = i - 1)
			bitx(d[i], q[i]);
		bitx(b9, r);
	endtask
	task recover;
		integer k;
		reg r;
		r = 1'b0;
		for (k = 0; k < 9 && r !== 1'b1; k = k + 1)
			bitx(1'b1, r);
		cond(1'b1);
	endtask
endmodule // tws_master

// >>> test/tws_slave_bench.sv
// Bench of the serial memory slave: a table of byte writes, then edge cases.
// Assumes tws_master drives the bus and tws_chk is bound to the slave.
`timescale 1ns/100ps
module tws_slave_bench;
	reg clk;
	reg resetn;
	reg wp;
	reg [2:0] st;
	reg [7:0] ak;
	reg [7:0] q;
	reg [22:0] rows [0:2];
	integer mismatches = 0;
	integer tests_run = 0;
	integer cyc = 0;
	integer i;
	wire scl;
	wire m_low;
	wire sda_oe;
	wire busy;
	wire sda = !(sda_oe || m_low);
	wire [7:0] dw = {4'ha, st, 1'b0};
	tws_slave #(.ADDR_BITS(15), .WR_CYCLES(2000)) dut_u (.clk(clk), .resetn(resetn),
		.scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
		.chip_select_strap_0(st[0]), .chip_select_strap_1(st[1]),
		.chip_select_strap_2(st[2]), .write_protect(wp), .busy(busy));
	tws_master m_u (.clk(clk), .sda(sda), .scl(scl), .sda_low(m_low));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = !clk;
	end
	always @(posedge clk)
	begin
		cyc = cyc + 1;
		if (cyc == 60000)
		begin
			mismatches = mismatches + 1;
			summarize;
		end
	end
	task summarize;
		if (mismatches == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input string nm, input [7:0] seen, input [7:0] exp);
		tests_run = tests_run + 1;
		if (seen !== exp)
		begin
			mismatches = mismatches + 1;
			$display("FAIL %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task tx(input [7:0] d, input [7:0] e);
		m_u.xfer(d, 1'b1, q, ak[0]);
		chk("ack", ak, e);
	endtask
	task seta(input [14:0] a);
		m_u.cond(1'b1);
		tx(dw, 8'h00);
		tx({1'b0, a[14:8]}, 8'h00);
		tx(a[7:0], 8'h00);
	endtask
	task rsta;
		m_u.cond(1'b1);
		tx(dw | 8'h01, 8'h00);
	endtask
	task rd(input m, input [7:0] e);
		m_u.xfer(8'hff, m, q, ak[0]);
		chk("read", q, e);
	endtask
	task idle;
		integer n;
		chk("busy", {7'h0, busy}, 8'h01);
		for (n = 0; n < 3000 && busy !== 1'b0; n = n + 1)
			@(negedge clk);
		chk("busy", {7'h0, busy}, 8'h00);
	endtask
	initial
	begin
		resetn = 1'b0;
		wp = 1'b0;
		st = 3'h5;
		ak = 8'h00;
		rows[0] = {15'h0000, 8'h5a};
		rows[1] = {15'h0001, 8'ha5};
		rows[2] = {15'h7fff, 8'h81};
		repeat (20) @(negedge clk);
		resetn = 1'b1;
		repeat (8) @(negedge clk);
		for (i = 0; i < 3; i = i + 1)
		begin
			seta(rows[i][22:8]);
			tx(rows[i][7:0], 8'h00);
			m_u.cond(1'b0);
			idle;
			seta(rows[i][22:8]);
			rsta;
			rd(1'b1, rows[i][7:0]);
			m_u.cond(1'b0);
		end
		rsta;
		rd(1'b0, 8'h5a);
		rd(1'b1, 8'ha5);
		m_u.cond(1'b0);
		seta(15'h1a7e);
		tx(8'h11, 8'h00);
		tx(8'h22, 8'h00);
		tx(8'h33, 8'h00);
		tx(8'h44, 8'h00);
		for (i = 0; i < 6; i = i + 1)
			tx(8'h55 + i[7:0], 8'h00);
		m_u.cond(1'b0);
		m_u.cond(1'b1);
		tx(dw, 8'h01);
		m_u.cond(1'b0);
		idle;
		seta(15'h1a40);
		rsta;
		rd(1'b0, 8'h33);
		rd(1'b0, 8'h44);
		for (i = 0; i < 6; i = i + 1)
			rd(i == 5, 8'h55 + i[7:0]);
		m_u.cond(1'b0);
		st = 3'h2;
		for (i = 0; i < 2; i = i + 1)
		begin
			m_u.cond(1'b1);
			tx(i ? 8'haa : 8'h24, 8'h01);
			m_u.cond(1'b0);
		end
		wp = 1'b1;
		seta(15'h0001);
		tx(8'hee, 8'h00);
		m_u.cond(1'b0);
		repeat (50) @(negedge clk);
		chk("busy", {7'h0, busy}, 8'h00);
		wp = 1'b0;
		seta(15'h0001);
		rsta;
		rd(1'b1, 8'ha5);
		m_u.cond(1'b0);
		m_u.cond(1'b1);
		tx(dw, 8'h00);
		resetn = 1'b0;
		repeat (20) @(negedge clk);
		chk("oe", {7'h0, sda_oe}, 8'h00);
		resetn = 1'b1;
		repeat (8) @(negedge clk);
		m_u.recover;
		tx(dw, 8'h00);
		m_u.cond(1'b0);
		chk("busy", {7'h0, busy}, 8'h00);
		summarize;
	end
endmodule // tws_slave_bench
